// >>> tcc_pkg.sv
package tcc_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_CH0_SC = 8'h00;
    localparam logic [7:0] ADDR_CH0_VH = 8'h04;
    localparam logic [7:0] ADDR_CH0_VL = 8'h08;
    localparam logic [7:0] ADDR_CH1_SC = 8'h0c;
    localparam logic [7:0] ADDR_CH1_VH = 8'h10;
    localparam logic [7:0] ADDR_CH1_VL = 8'h14;

    // Status/control field positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_MSB = 5;
    localparam int BIT_MSA = 4;
    localparam int BIT_ELSB = 3;
    localparam int BIT_ELSA = 2;
    localparam int BIT_TOV = 1;
    localparam int BIT_MAX = 0;

    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_LOW = 2'h2;
    localparam logic [1:0] ELS_HIGH = 2'h3;

    typedef enum logic [1:0] {
        MODE_PRESET = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_COMPARE = 2'b11,
        MODE_BUFFERED = 2'b10
    } chan_mode_t;

    typedef struct packed {
        logic flag;
        logic ie;
        logic msb;
        logic msa;
        logic [1:0] els;
        logic tov;
        logic max;
    } chan_ctrl_t;

    typedef struct packed {
        logic [15:0] count;
        logic wrap;
        logic counter_halt;
        logic debug_break;
    } timer_core_t;

    function automatic chan_mode_t mode_of(input logic msb, input logic msa,
                                           input logic [1:0] els);
        if (els == ELS_OFF) begin
            return MODE_PRESET;
        end else if (msb) begin
            return MODE_BUFFERED;
        end else if (msa) begin
            return MODE_COMPARE;
        end
        return MODE_CAPTURE;
    endfunction

endpackage

// >>> edge_sense.sv
module edge_sense
    import tcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire logic [1:0] els,
    output logic hit
);
    logic prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
        end else begin
            prev <= pin_in;
        end
    end

    always_comb begin
        unique case (els)
            ELS_TOGGLE: hit = pin_in & ~prev;
            ELS_LOW: hit = ~pin_in & prev;
            ELS_HIGH: hit = pin_in ^ prev;
            default: hit = 1'b0;
        endcase
    end
endmodule // edge_sense

// >>> pin_action.sv
module pin_action
    import tcc_pkg::*;
(
    input wire logic cur,
    input wire logic [1:0] els,
    input wire logic match,
    input wire logic wrap,
    input wire logic tov,
    output logic next_level
);
    always_comb begin
        next_level = cur;
        if (tov && wrap) begin
            next_level = ~cur;
        end else if (match) begin
            unique case (els)
                ELS_TOGGLE: next_level = ~cur;
                ELS_LOW: next_level = 1'b0;
                ELS_HIGH: next_level = 1'b1;
                default: next_level = cur;
            endcase
        end
    end
endmodule // pin_action

// >>> timer_channel_capture_compare.sv
// Function
// - Capture mode: active edge sets flag and latches counter value.
// - Compare mode: counter equal to channel value sets flag.
// - With interrupt enabled, flag clears by status read then zero write.
// - With interrupt enabled, event between read and zero write keeps the flag set.
// - Reset clears flags; writing one to a flag does nothing.
// - Interrupt request only while enable and flag both set; reset clears enable.
// - Buffered select exists in channel 0 only, disabling channel 1.
// - Edge field nonzero, unbuffered: select A one compare, zero capture.
// - Edge field zero: port owns pin; select A presets output level.
// - Capture edge: 01 rising, 10 falling, 11 either.
// - Compare pin action: 00 none, 01 toggle, 10 low, 11 high.
// - Edge field zero disconnects pin; enabled modes make channel transparent.
// - Toggle-on-wrap toggles compare output every overflow; ignored in capture.
// - Overflow action wins over coincident compare action.
// - Full duty force with toggle and drive-low keeps output high.
// - Full duty change takes effect from the next period.
// - Each channel has read/write 16-bit value register, undefined at reset.
// - Capture: reading high byte blocks captures until low byte read.
// - Compare: writing high byte blocks matches until low byte written.
// - Counter halt blocks captures on all channels.
// - Debug break blocks captures.
module timer_channel_capture_compare
    import tcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire timer_core_t core,
    input wire logic [1:0] chan_pin_in,
    output logic [1:0] chan_pin_out,
    output logic [1:0] chan_pin_oe,
    output logic [1:0] chan_irq
);
    chan_ctrl_t sc [2];
    logic [15:0] value [2];
    logic [1:0] armed;
    logic [1:0] cap_lock;
    logic [1:0] cmp_lock;
    logic [7:0] hi_stage [2];
    logic [1:0] level;
    logic [1:0] max_active;
    logic buf_sel;
    logic [1:0] hit;
    logic [1:0] match;
    logic [1:0] next_level;
    logic [1:0] event_set;
    chan_mode_t mode [2];
    logic bus_wr;
    logic bus_rd;
    logic [15:0] buf_cmp;

    assign bus_wr = psel & penable & pwrite;
    assign bus_rd = psel & penable & ~pwrite;

    // Buffered mode lives in channel 0; it owns channel 1's value register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_sel <= 1'b0;
        end else if (!sc[0].msb) begin
            buf_sel <= 1'b0;
        end else if (core.wrap) begin
            buf_sel <= ~buf_sel;
        end
    end

    assign buf_cmp = buf_sel ? value[1] : value[0];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : chan
            logic ch_off;
            logic [7:0] sc_addr;
            logic [7:0] vh_addr;
            logic [7:0] vl_addr;

            assign ch_off = (g == 1) && sc[0].msb;
            assign sc_addr = (g == 0) ? ADDR_CH0_SC : ADDR_CH1_SC;
            assign vh_addr = (g == 0) ? ADDR_CH0_VH : ADDR_CH1_VH;
            assign vl_addr = (g == 0) ? ADDR_CH0_VL : ADDR_CH1_VL;
            assign mode[g] = ch_off ? MODE_PRESET
                                    : mode_of((g == 0) & sc[g].msb, sc[g].msa, sc[g].els);

            edge_sense u_edge (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(chan_pin_in[g]),
                .els(sc[g].els),
                .hit(hit[g])
            );

            assign match[g] = (mode[g] == MODE_COMPARE && core.count == value[g])
                            || (g == 0 && mode[g] == MODE_BUFFERED && core.count == buf_cmp);

            pin_action u_act (
                .cur(level[g]),
                .els(sc[g].els),
                .match(match[g] & ~cmp_lock[g]),
                .wrap(core.wrap),
                .tov(sc[g].tov & (mode[g] != MODE_CAPTURE)),
                .next_level(next_level[g])
            );

            assign event_set[g] =
                (mode[g] == MODE_CAPTURE && hit[g] && !cap_lock[g]
                 && !core.counter_halt && !core.debug_break)
                || (match[g] && !cmp_lock[g]);

            // Control bits other than the flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sc[g].ie <= 1'b0;
                    sc[g].msb <= 1'b0;
                    sc[g].msa <= 1'b0;
                    sc[g].els <= ELS_OFF;
                    sc[g].tov <= 1'b0;
                    sc[g].max <= 1'b0;
                end else if (bus_wr && paddr == sc_addr && !ch_off) begin
                    sc[g].ie <= pwdata[BIT_IE];
                    sc[g].msb <= (g == 0) ? pwdata[BIT_MSB] : 1'b0;
                    sc[g].msa <= pwdata[BIT_MSA];
                    sc[g].els <= pwdata[BIT_ELSB:BIT_ELSA];
                    sc[g].tov <= pwdata[BIT_TOV];
                    sc[g].max <= pwdata[BIT_MAX];
                end
            end

            // Flag: set wins over the clear; with interrupt enabled, clear needs a prior read of it set
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sc[g].flag <= 1'b0;
                    armed[g] <= 1'b0;
                end else if (event_set[g]) begin
                    sc[g].flag <= 1'b1;
                    armed[g] <= 1'b0;
                end else if (bus_rd && paddr == sc_addr && sc[g].flag) begin
                    armed[g] <= 1'b1;
                end else if (bus_wr && paddr == sc_addr && !pwdata[BIT_FLAG]) begin
                    if (armed[g] || !sc[g].ie) begin
                        sc[g].flag <= 1'b0;
                    end
                    armed[g] <= 1'b0;
                end
            end

            // Value register: capture, byte writes and the locks
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cap_lock[g] <= 1'b0;
                    cmp_lock[g] <= 1'b0;
                    hi_stage[g] <= 8'h00;
                end else begin
                    if (bus_rd && paddr == vh_addr && mode[g] == MODE_CAPTURE) begin
                        cap_lock[g] <= 1'b1;
                    end else if (bus_rd && paddr == vl_addr) begin
                        cap_lock[g] <= 1'b0;
                    end
                    if (bus_wr && paddr == vh_addr) begin
                        hi_stage[g] <= pwdata[7:0];
                        cmp_lock[g] <= (mode[g] == MODE_COMPARE) || (mode[g] == MODE_BUFFERED)
                                    || ch_off;
                    end else if (bus_wr && paddr == vl_addr) begin
                        cmp_lock[g] <= 1'b0;
                    end
                end
            end

            // No reset: contents are undefined after reset
            always_ff @(posedge pclk) begin
                if (mode[g] == MODE_CAPTURE && event_set[g]) begin
                    value[g] <= core.count;
                end else if (bus_wr && paddr == vl_addr) begin
                    value[g] <= {cmp_lock[g] ? hi_stage[g] : value[g][15:8],
                                 pwdata[7:0]};
                end else if (bus_wr && paddr == vh_addr && mode[g] == MODE_CAPTURE) begin
                    value[g][15:8] <= pwdata[7:0];
                end
            end

            // Full duty force latches only at a period boundary
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    max_active[g] <= 1'b0;
                end else if (core.wrap) begin
                    max_active[g] <= sc[g].max && sc[g].tov && sc[g].els == ELS_LOW;
                end
            end

            // Output level and pin ownership
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    level[g] <= 1'b1;
                    chan_pin_out[g] <= 1'b0;
                    chan_pin_oe[g] <= 1'b0;
                end else begin
                    if (mode[g] == MODE_PRESET) begin
                        level[g] <= ~sc[g].msa;
                    end else if (mode[g] != MODE_CAPTURE) begin
                        level[g] <= next_level[g];
                    end
                    chan_pin_out[g] <= max_active[g] ? 1'b1 : level[g];
                    chan_pin_oe[g] <= (mode[g] == MODE_COMPARE)
                                   || (mode[g] == MODE_BUFFERED);
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    chan_irq[g] <= 1'b0;
                end else begin
                    chan_irq[g] <= sc[g].ie & sc[g].flag & ~ch_off;
                end
            end

            a_flag_set_cause: assert property (@(posedge pclk) disable iff (!presetn)
                event_set[g] |=> sc[g].flag)
                else $error("flag not set after event");
            a_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
                chan_irq[g] |-> $past(sc[g].ie) && $past(sc[g].flag))
                else $error("irq without enable and flag");
            a_one_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
                sc[g].flag && !event_set[g] && bus_wr && paddr == sc_addr
                && pwdata[BIT_FLAG] |=> sc[g].flag)
                else $error("writing one cleared flag");
            a_clear_needs_read: assert property (@(posedge pclk) disable iff (!presetn)
                sc[g].flag && sc[g].ie && !armed[g] |=> sc[g].flag)
                else $error("flag cleared without read");
            a_event_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
                event_set[g] && bus_wr && paddr == sc_addr |=> sc[g].flag)
                else $error("event lost during clear");
            a_capture_blocked: assert property (@(posedge pclk) disable iff (!presetn)
                (core.counter_halt || core.debug_break || cap_lock[g])
                && mode[g] == MODE_CAPTURE |-> !event_set[g])
                else $error("capture while blocked");
            a_compare_locked: assert property (@(posedge pclk) disable iff (!presetn)
                cmp_lock[g] |-> !event_set[g] || mode[g] == MODE_CAPTURE)
                else $error("compare while locked");
            a_preset_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
                mode[g] == MODE_PRESET |=> !chan_pin_oe[g])
                else $error("pin driven in preset");
            a_full_duty_high: assert property (@(posedge pclk) disable iff (!presetn)
                max_active[g] |=> chan_pin_out[g])
                else $error("full duty not high");
        end
    endgenerate

    // APB slave: zero wait states, unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > ADDR_CH1_VL || paddr[1:0] != 2'h0);
            unique case (paddr)
                ADDR_CH0_SC: prdata <= {24'h000000, sc[0]};
                ADDR_CH1_SC: prdata <= {24'h000000, sc[1]};
                ADDR_CH0_VH: prdata <= {24'h000000, value[0][15:8]};
                ADDR_CH0_VL: prdata <= {24'h000000, value[0][7:0]};
                ADDR_CH1_VH: prdata <= {24'h000000, value[1][15:8]};
                ADDR_CH1_VL: prdata <= {24'h000000, value[1][7:0]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // timer_channel_capture_compare

// >>> pin_load_model.sv
module pin_load_model (
    input wire logic pclk,
    input wire logic [1:0] src_level,
    input wire logic [1:0] chan_pin_out,
    input wire logic [1:0] chan_pin_oe,
    output logic [1:0] pin_level
);
    logic [1:0] src_q;
    // Source level moves only on a clock edge, so it holds between edges
    always_ff @(posedge pclk) begin
        src_q <= src_level;
    end
    // Port or external source owns the wire unless the channel drives it
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_level[i] = chan_pin_oe[i] ? chan_pin_out[i] : src_q[i];
        end
    end
endmodule // pin_load_model

// >>> timer_channel_capture_compare_tb_top.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module timer_channel_capture_compare_tb_top
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    timer_core_t core = '0;
    logic [1:0] src = 2'h0;
    logic [1:0] pin;
    logic [1:0] pout;
    logic [1:0] poe;
    logic [1:0] irq;
    logic [31:0] rd;
    logic er;
    logic [15:0] cnt;
    logic [15:0] v;
    int fails = 0;
    int n_compared = 0;
    int seed = 32'h2628;

    always #20 pclk = ~pclk;

    timer_channel_capture_compare DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
        .chan_pin_in(pin), .chan_pin_out(pout), .chan_pin_oe(poe), .chan_irq(irq));
    pin_load_model far_side (.pclk(pclk), .src_level(src), .chan_pin_out(pout),
        .chan_pin_oe(poe), .pin_level(pin));

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Idle count sits far from the compare value so only pulses match
    task automatic pulse(input logic m, input logic w);
        core.count <= m ? v : v ^ 16'h8000;
        core.wrap <= w;
        @(posedge pclk);
        core.count <= v ^ 16'h8000;
        core.wrap <= 1'b0;
        cycles(3);
    endtask

    function automatic logic [7:0] adr(input int c, input int k);
        return (c != 0 ? ADDR_CH1_SC : ADDR_CH0_SC) + 8'(4 * k);
    endfunction

    function automatic logic hit_exp(input logic [1:0] e, input logic rise);
        return rise ? e[0] : e[1];
    endfunction

    function automatic logic lvl_exp(input logic [1:0] e, input logic cur);
        case (e)
            2'h1: return ~cur;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return cur;
        endcase
    endfunction

    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        wrap_up();
    end

    initial begin
        cycles(2);
        presetn <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            rdr(adr(c, 0));
            `CHK(rd[7:0], SC_RESET)
        end
        rdr(8'h18);
        `CHK(er, 1'b1)
        wr(8'h02, 32'h0);
        `CHK(er, 1'b1)
        wr(ADDR_CH0_SC, 32'h80);
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_FLAG], 1'b0)
        for (int c = 0; c < 2; c++) begin
            for (int e = 1; e < 4; e++) begin
                cnt = 16'($random(seed));
                core.count <= cnt;
                wr(adr(c, 0), 32'(e << 2));
                cycles(3);
                for (int r = 1; r >= 0; r--) begin
                    src[c] <= 1'(r);
                    cycles(5);
                    rdr(adr(c, 0));
                    `CHK(rd[BIT_FLAG], hit_exp(2'(e), 1'(r)))
                    if (hit_exp(2'(e), 1'(r))) begin
                        rdr(adr(c, 1));
                        `CHK(rd[7:0], cnt[15:8])
                        rdr(adr(c, 2));
                        `CHK(rd[7:0], cnt[7:0])
                    end
                    wr(adr(c, 0), 32'(e << 2));
                end
            end
        end
        cnt = 16'($random(seed));
        core.count <= cnt;
        src[0] <= 1'b1;
        cycles(5);
        rdr(ADDR_CH0_VH);
        core.count <= ~cnt;
        src[0] <= 1'b0;
        cycles(3);
        src[0] <= 1'b1;
        cycles(5);
        rdr(ADDR_CH0_VL);
        `CHK(rd[7:0], cnt[7:0])
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CH0_SC, 32'h04);
            core.counter_halt <= (k == 0);
            core.debug_break <= (k == 1);
            src[0] <= 1'b0;
            cycles(3);
            src[0] <= 1'b1;
            cycles(5);
            rdr(ADDR_CH0_SC);
            `CHK(rd[BIT_FLAG], 1'b0)
            core.counter_halt <= 1'b0;
            core.debug_break <= 1'b0;
        end
        v = 16'($random(seed));
        core.count <= v ^ 16'h8000;
        wr(ADDR_CH0_VH, 32'(v[15:8]));
        wr(ADDR_CH0_VL, 32'(v[7:0]));
        rdr(ADDR_CH0_VH);
        `CHK(rd[7:0], v[15:8])
        for (int e = 1; e < 4; e++) begin
            core.counter_halt <= 1'b1;
            wr(ADDR_CH0_SC, 32'h10);
            cycles(2);
            `CHK(poe[0], 1'b0)
            wr(ADDR_CH0_SC, 32'(8'h10 | e << 2));
            core.counter_halt <= 1'b0;
            pulse(1'b1, 1'b0);
            `CHK(pout[0], lvl_exp(2'(e), 1'b0))
            `CHK(poe[0], 1'b1)
            rdr(ADDR_CH0_SC);
            `CHK(rd[BIT_FLAG], 1'b1)
        end
        wr(ADDR_CH0_SC, 32'h1c);
        wr(ADDR_CH0_VH, 32'(~v[15:8]));
        pulse(1'b1, 1'b0);
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_FLAG], 1'b0)
        wr(ADDR_CH0_VL, 32'(v[7:0]));
        v = {~v[15:8], v[7:0]};
        pulse(1'b1, 1'b0);
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_FLAG], 1'b1)
        `CHK(irq[0], 1'b0)
        wr(ADDR_CH0_SC, 32'h1c);
        wr(ADDR_CH0_SC, 32'h5c);
        pulse(1'b1, 1'b0);
        `CHK(irq[0], 1'b1)
        wr(ADDR_CH0_SC, 32'h5c);
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_FLAG], 1'b1)
        pulse(1'b1, 1'b0);
        wr(ADDR_CH0_SC, 32'h5c);
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_FLAG], 1'b1)
        wr(ADDR_CH0_SC, 32'h5c);
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_FLAG], 1'b0)
        cycles(2);
        `CHK(irq[0], 1'b0)
        wr(ADDR_CH0_SC, 32'h10);
        // Drive-low on match so the wrap toggle is the only way to go high
        wr(ADDR_CH0_SC, 32'h1a);
        pulse(1'b1, 1'b1);
        `CHK(pout[0], 1'b1)
        pulse(1'b0, 1'b1);
        `CHK(pout[0], 1'b0)
        wr(ADDR_CH0_SC, 32'h10);
        wr(ADDR_CH0_SC, 32'h1b);
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b0);
        `CHK(pout[0], 1'b1)
        wr(ADDR_CH0_SC, 32'h1a);
        pulse(1'b1, 1'b0);
        `CHK(pout[0], 1'b1)
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b0);
        `CHK(pout[0], 1'b0)
        wr(ADDR_CH0_SC, 32'h18);
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b0);
        `CHK(pout[0], 1'b0)
        wr(ADDR_CH1_SC, 32'h20);
        rdr(ADDR_CH1_SC);
        `CHK(rd[7:0], 8'h00)
        wr(ADDR_CH0_SC, 32'h2c);
        wr(ADDR_CH1_SC, 32'h1c);
        rdr(ADDR_CH1_SC);
        `CHK(rd[7:0], 8'h00)
        `CHK(poe[1], 1'b0)
        rdr(ADDR_CH0_SC);
        `CHK(rd[BIT_MSB], 1'b1)
        presetn <= 1'b0;
        cycles(2);
        presetn <= 1'b1;
        rdr(ADDR_CH0_SC);
        `CHK(rd[7:0], SC_RESET)
        wrap_up();
    end
endmodule // timer_channel_capture_compare_tb_top
